// ---- core/suvg_gate.sv ----
/*
  supply undervoltage gating: derives channel, serial port and register enables
  from the main-supply and logic-supply monitor flags, the idle pin and the input pins.
  assumes flags and pins are asynchronous to mclk; channel requests come from mclk logic.
  assumes channel requests already merge register bits and pin mappings upstream.
*/
// Notes on behaviour
// - With both supplies in undervoltage, no power stage turns on, serial access is refused and registers are reset.
// - With the logic supply in undervoltage, serial transfers are ignored and writable registers reset.
// - Main-supply undervoltage turns all channels off until the supply is back at the operating threshold.
// - Between undervoltage and operating threshold, channels already on stay on until commanded off; new turn-ons are refused.
// - With the logic supply in undervoltage, the serial interface cannot control any channel.
// - With the main supply at or below 3.0 V no channel is controllable by serial port or pins.
// - At or below 3.0 V main supply with logic supply good, registers stay usable and fallback mode may be entered with channels off.
// - At or below 3.0 V main supply with logic supply in undervoltage, fallback mode is not entered.
// - Fallback mode is entered with idle low and any input high; the default channel of that pin turns on once the main supply
//   is back at the operating threshold and, with the logic supply good, registers go read-only.
module suvg_gate
  import suvg_pkg::*;
#(
  parameter int unsigned num_channels = suvg_num_channels
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic main_crank_low,
  input wire logic main_undervoltage,
  input wire logic main_below_operating,
  input wire logic logic_undervoltage,
  input wire logic idle_n,
  input wire logic [1:0] direct_input_pins,
  input wire logic [num_channels-1:0] serial_channel_request,
  input wire logic [num_channels-1:0] pin_channel_request,
  output logic [num_channels-1:0] channel_enable,
  output logic serial_port_enable,
  output logic register_reset,
  output logic register_read_only,
  output logic fallback_mode,
  output suvg_region_type main_region
);
  // ****************************************
  // parameter check
  // ****************************************
  // default pin channels 2 and 3 must exist, and the pin map is eight bits wide
  if (num_channels < 4 || num_channels > 8) begin : g_bad_channels
    $error("suvg_gate: num_channels must be 4 to 8");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [suvg_sync_width-1:0] async_in;
  logic [suvg_sync_width-1:0] s1_q;
  logic [suvg_sync_width-1:0] s2_q;
  logic [suvg_sync_width-1:0] s3_q;
  logic [suvg_sync_width-1:0] clean_q;
  logic [suvg_sync_width-1:0] clean_d;

  // keeps its value until stages two and three agree, so a lone odd sample is dropped
  function automatic logic [suvg_sync_width-1:0] settle(
    input logic [suvg_sync_width-1:0] newer,
    input logic [suvg_sync_width-1:0] older,
    input logic [suvg_sync_width-1:0] held
  );
    settle = (newer & older) | ((newer | older) & held);
  endfunction : settle

  assign async_in = {main_crank_low, main_undervoltage, main_below_operating,
                     logic_undervoltage, idle_n, direct_input_pins};
  assign clean_d = settle(s2_q, s3_q, clean_q);

  // first stage: may go metastable, only the second stage reads it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= suvg_sync_reset_value;
    end else begin
      s1_q <= async_in;
    end
  end

  // second stage: the first flop that is safe to read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s2_q <= suvg_sync_reset_value;
    end else begin
      s2_q <= s1_q;
    end
  end

  // third stage: compared with the second before a change counts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s3_q <= suvg_sync_reset_value;
    end else begin
      s3_q <= s2_q;
    end
  end

  // flags start flagged bad so nothing turns on before real samples arrive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clean_q <= suvg_sync_reset_value;
    end else begin
      clean_q <= clean_d;
    end
  end

  // ****************************************
  // decoded supply state
  // ****************************************
  // only filtered copies are used below, never the raw pins
  wire crank_low = clean_q[6];
  wire main_uv = clean_q[5];
  wire main_below_op = clean_q[4];
  wire logic_uv = clean_q[3];
  wire idle_high = clean_q[2];
  wire [1:0] pins_high = clean_q[1:0];
  wire any_pin_high = |pins_high;

  wire both_uv = main_uv && logic_uv;
  wire serial_ok = !logic_uv;
  wire fallback_req = !idle_high && any_pin_high && !(crank_low && logic_uv);

  // priority: off over undervoltage over hold over full
  assign main_region = crank_low ? suvg_region_off :
                       main_uv ? suvg_region_crank :
                       main_below_op ? suvg_region_hold : suvg_region_full;

  // ****************************************
  // channel requests
  // ****************************************
  function automatic logic [7:0] pin_mask(input logic pin_high, input logic [7:0] map);
    pin_mask = {8{pin_high}} & map;
  endfunction : pin_mask

  // default channels of every pin that is high; in fallback mode these replace the mapped requests
  // the programmable pin mapping is ignored there
  wire [7:0] default_map = pin_mask(pins_high[0], suvg_input0_channel_map)
                         | pin_mask(pins_high[1], suvg_input1_channel_map);
  wire [num_channels-1:0] fallback_channels = default_map[num_channels-1:0];
  // serial requests count only with the logic supply good and outside fallback mode
  wire [num_channels-1:0] serial_req = (serial_ok && !fallback_req) ? serial_channel_request : '0;
  wire [num_channels-1:0] pin_req = fallback_req ? fallback_channels : pin_channel_request;
  wire [num_channels-1:0] request = serial_req | pin_req;

  logic [num_channels-1:0] chan_q;
  logic [num_channels-1:0] chan_d;
  // hold region: new turn-ons are refused, a channel stays on only while still requested
  wire [num_channels-1:0] hold_chan = chan_q & request;

  always_comb begin
    case (main_region)
      suvg_region_off: chan_d = '0;
      suvg_region_crank: chan_d = '0;
      suvg_region_hold: chan_d = hold_chan;
      suvg_region_full: chan_d = request;
      default: chan_d = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chan_q <= '0;
    end else begin
      chan_q <= chan_d;
    end
  end

  // ****************************************
  // serial port and register control
  // ****************************************
  logic port_q;
  logic regrst_q;
  logic ro_q;
  logic fb_q;

  // serial access needs the logic supply, which also covers the both-undervoltage case
  wire port_d = serial_ok && !both_uv;
  wire regrst_d = logic_uv;
  wire ro_d = fallback_req && serial_ok;
  wire fb_d = fallback_req;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_q <= 1'b0;
    end else begin
      port_q <= port_d;
    end
  end

  // registers are held in reset from power-up until the logic supply is seen good
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regrst_q <= 1'b1;
    end else begin
      regrst_q <= regrst_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ro_q <= 1'b0;
    end else begin
      ro_q <= ro_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fb_q <= 1'b0;
    end else begin
      fb_q <= fb_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  assign channel_enable = chan_q;
  assign serial_port_enable = port_q;
  assign register_reset = regrst_q;
  assign register_read_only = ro_q;
  assign fallback_mode = fb_q;
endmodule : suvg_gate

// ---- inc/suvg_pkg.sv ----
/*
  constants and types for the supply undervoltage gating block.
  assumes one 25 mhz clock and monitor flags from analog comparators.
*/
package suvg_pkg;
  // ****************************************
  // sizes and defaults
  // ****************************************
  localparam int unsigned suvg_num_channels = 8;
  localparam int unsigned suvg_num_inputs = 2;
  localparam logic [7:0] suvg_input0_channel_map = 8'h04;
  localparam logic [7:0] suvg_input1_channel_map = 8'h08;
  localparam logic suvg_flag_reset_value = 1'b1;
  localparam int unsigned suvg_sync_width = 7;
  // flags start flagged bad, idle reads high, both input pins read low
  localparam logic [suvg_sync_width-1:0] suvg_sync_reset_value = {{4{suvg_flag_reset_value}}, 1'b1, 2'b00};

  // ****************************************
  // supply gating regions
  // ****************************************
  typedef enum logic [1:0] {
    suvg_region_off,
    suvg_region_crank,
    suvg_region_hold,
    suvg_region_full
  } suvg_region_type;
endpackage : suvg_pkg

// ---- sim/suvg_gate_properties.sv ----
/* assertions on the ports of suvg_gate.
   assumes mclk and an async active high rst. */
module suvg_gate_properties
  import suvg_pkg::*;
#(parameter int unsigned num_channels = suvg_num_channels) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic main_crank_low,
  input wire logic main_undervoltage,
  input wire logic main_below_operating,
  input wire logic logic_undervoltage,
  input wire logic idle_n,
  input wire logic [1:0] direct_input_pins,
  input wire logic [num_channels-1:0] serial_channel_request,
  input wire logic [num_channels-1:0] pin_channel_request,
  input wire logic [num_channels-1:0] channel_enable,
  input wire logic serial_port_enable,
  input wire logic register_reset,
  input wire logic register_read_only,
  input wire logic fallback_mode
);
  timeunit 1ns / 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire ok = !main_below_operating && !main_undervoltage && !main_crank_low && !logic_undervoltage && idle_n;
  sequence full_quiet;
    (ok && $stable(serial_channel_request) && $stable(pin_channel_request))[*7];
  endsequence
  a_luv_reset: assert property (logic_undervoltage[*7] |-> register_reset && !serial_port_enable)
    else $error("reset");
  a_both_off: assert property ((logic_undervoltage && main_undervoltage)[*7] |-> channel_enable == 0)
    else $error("both");
  a_uv_off: assert property (main_undervoltage[*7] |-> channel_enable == 0) else $error("uv");
  a_crank_off: assert property (main_crank_low[*7] |-> channel_enable == 0) else $error("crank");
  a_crank_nofb: assert property ((main_crank_low && logic_undervoltage)[*7] |-> !fallback_mode)
    else $error("fb");
  a_hold_keep: assert property ((main_below_operating && !main_undervoltage && !main_crank_low && idle_n)[*7]
    |-> (channel_enable & ~$past(channel_enable)) == 0) else $error("hold");
  a_full_follow: assert property (full_quiet |-> channel_enable == (serial_channel_request | pin_channel_request))
    else $error("full");
  a_fb_enter: assert property ((!idle_n && |direct_input_pins && !logic_undervoltage)[*7]
    |-> fallback_mode && register_read_only) else $error("enter");
  a_luv_serial: assert property ((logic_undervoltage && idle_n && pin_channel_request == '0)[*7]
    |-> channel_enable == '0) else $error("serial control during logic undervoltage");
  a_crank_regs: assert property ((main_crank_low && !logic_undervoltage)[*7]
    |-> !register_reset && serial_port_enable) else $error("registers lost at crank");
endmodule : suvg_gate_properties
bind suvg_gate suvg_gate_properties #(.num_channels(num_channels)) suvg_gate_properties_i (
  .mclk(mclk),
  .rst(rst),
  .main_crank_low(main_crank_low),
  .main_undervoltage(main_undervoltage),
  .main_below_operating(main_below_operating),
  .logic_undervoltage(logic_undervoltage),
  .idle_n(idle_n),
  .direct_input_pins(direct_input_pins),
  .serial_channel_request(serial_channel_request),
  .pin_channel_request(pin_channel_request),
  .channel_enable(channel_enable),
  .serial_port_enable(serial_port_enable),
  .register_reset(register_reset),
  .register_read_only(register_read_only),
  .fallback_mode(fallback_mode)
);

// ---- sim/suvg_gate_test.sv ----
/* bench for suvg_gate: scenario tasks drive pins and requests.
   assumes the supply model owns the flags. */
module suvg_gate_test
  import suvg_pkg::*;
;
  timeunit 1ns / 1ps;
  logic mclk = 1'b0, rst = 1'b1, idle_n = 1'b1;
  logic [1:0] direct_input_pins = 2'h0;
  logic [7:0] serial_channel_request = 8'h00, pin_channel_request = 8'h00, channel_enable;
  logic main_crank_low, main_undervoltage, main_below_operating, logic_undervoltage;
  logic serial_port_enable, register_reset, register_read_only, fallback_mode;
  suvg_region_type main_region;
  int fail_count = 0, checks_done = 0;
  suvg_supply_model suvg_supply_model_i (
    .main_crank_low(main_crank_low),
    .main_undervoltage(main_undervoltage),
    .main_below_operating(main_below_operating),
    .logic_undervoltage(logic_undervoltage)
  );
  suvg_gate suvg_gate_i (
    .mclk(mclk),
    .rst(rst),
    .main_crank_low(main_crank_low),
    .main_undervoltage(main_undervoltage),
    .main_below_operating(main_below_operating),
    .logic_undervoltage(logic_undervoltage),
    .idle_n(idle_n),
    .direct_input_pins(direct_input_pins),
    .serial_channel_request(serial_channel_request),
    .pin_channel_request(pin_channel_request),
    .channel_enable(channel_enable),
    .serial_port_enable(serial_port_enable),
    .register_reset(register_reset),
    .register_read_only(register_read_only),
    .fallback_mode(fallback_mode),
    .main_region(main_region)
  );
  task finish_test();
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task check(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask : check
  task step(input logic [3:0] f, input logic [18:0] d, input logic [13:0] e);
    suvg_supply_model_i.put(f);
    {serial_channel_request, pin_channel_request, idle_n, direct_input_pins} = d;
    repeat (8) @(negedge mclk);
    check({channel_enable, serial_port_enable, register_reset, register_read_only, fallback_mode, main_region}, e);
  endtask : step
  task t_supply();
    step(4'h0, {8'h81, 8'h00, 3'h4}, {8'h81, 6'h23});
    step(4'h2, {8'h81, 8'h00, 3'h4}, {8'h81, 6'h22});
    step(4'h2, {8'h83, 8'h00, 3'h4}, {8'h81, 6'h22});
    step(4'h6, {8'h81, 8'h00, 3'h4}, {8'h00, 6'h21});
    step(4'h0, {8'h81, 8'h00, 3'h4}, {8'h81, 6'h23});
    step(4'h1, {8'h81, 8'h00, 3'h4}, {8'h00, 6'h13});
    step(4'h1, {8'h81, 8'h10, 3'h4}, {8'h10, 6'h13});
    step(4'h7, {8'h81, 8'h10, 3'h4}, {8'h00, 6'h11});
  endtask : t_supply
  task t_crank();
    step(4'he, {8'h81, 8'h10, 3'h1}, {8'h00, 6'h2c});
    step(4'hf, {8'h81, 8'h10, 3'h1}, {8'h00, 6'h10});
    step(4'h0, {8'h00, 8'h00, 3'h2}, {suvg_input1_channel_map, 6'h2f});
    step(4'h0, {8'h00, 8'h00, 3'h1}, {suvg_input0_channel_map, 6'h2f});
    step(4'h0, {8'h00, 8'h00, 3'h3}, {suvg_input0_channel_map | suvg_input1_channel_map, 6'h2f});
  endtask : t_crank
  initial forever #20 mclk = ~mclk;
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_supply();
    t_crank();
    finish_test();
  end
  initial begin
    repeat (500) @(negedge mclk);
    fail_count++;
    finish_test();
  end
endmodule : suvg_gate_test

// ---- sim/suvg_supply_model.sv ----
/* supply monitor model: the four flag levels.
   assumes put is called away from the rising edge. */
module suvg_supply_model (
  output logic main_crank_low,
  output logic main_undervoltage,
  output logic main_below_operating,
  output logic logic_undervoltage
);
  timeunit 1ns / 1ps;
  task put(input logic [3:0] f);
    {main_crank_low, main_undervoltage, main_below_operating, logic_undervoltage} = f;
  endtask : put
  initial put(4'hf);
endmodule : suvg_supply_model
